// ### stt_pins.sv
`timescale 1ns/100ps
`default_nettype none
module stt_pins (
  input wire logic clk,
  output var logic ext_pin,
  output var logic cap_pin,
  output logic tbc
);
  logic [1:0] div_reg = 2'h0;
  initial begin
    ext_pin = 1'b0;
    cap_pin = 1'b0;
  end
  always @(posedge clk) div_reg <= div_reg + 2'h1;
  assign tbc = div_reg == 2'h3;
  // level held for several clocks so the synchronised edge is never lost
  task automatic hit(input logic cap);
    @(posedge clk);
    if (cap) cap_pin <= 1'b1;
    else ext_pin <= 1'b1;
    repeat (4) @(posedge clk);
    cap_pin <= 1'b0;
    ext_pin <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : hit
endmodule : stt_pins
`default_nettype wire

// ### stt_pkg.sv
package stt_pkg;

  localparam int CNT_W = 10;
  localparam int P_W = 3;
  localparam int P_SHIFT = 7;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam int DIV_W = 6;

  // byte addresses of the byte-wide registers, one per 32-bit word
  localparam logic [4:0] OFS_CTL_ZERO = 5'h00;
  localparam logic [4:0] OFS_CTL_ONE = 5'h04;
  localparam logic [4:0] OFS_CNT_LOW = 5'h08;
  localparam logic [4:0] OFS_CNT_HIGH = 5'h0c;
  localparam logic [4:0] OFS_CMPA_LOW = 5'h10;
  localparam logic [4:0] OFS_CMPA_HIGH = 5'h14;
  localparam logic [4:0] OFS_FLAGS = 5'h18;

  localparam logic [1:0] MODE_COMPARE = 2'h0;
  localparam logic [1:0] MODE_CAPTURE = 2'h1;
  localparam logic [1:0] MODE_PWM_PULSE = 2'h2;
  localparam logic [1:0] MODE_TIMER = 2'h3;

  localparam logic [1:0] IO_CODE_0 = 2'h0;
  localparam logic [1:0] IO_CODE_1 = 2'h1;
  localparam logic [1:0] IO_CODE_2 = 2'h2;
  localparam logic [1:0] IO_CODE_3 = 2'h3;

  localparam logic [2:0] CLK_SYS_DIV4 = 3'h0;
  localparam logic [2:0] CLK_SYS = 3'h1;
  localparam logic [2:0] CLK_H_DIV16 = 3'h2;
  localparam logic [2:0] CLK_H_DIV64 = 3'h3;
  localparam logic [2:0] CLK_TBC = 3'h4;
  localparam logic [2:0] CLK_H_DIV8 = 3'h5;
  localparam logic [2:0] CLK_EXT_RISE = 3'h6;
  localparam logic [2:0] CLK_EXT_FALL = 3'h7;

  localparam logic [9:0] CNT_MAX = 10'h3ff;
  localparam logic [10:0] SPAN_FULL = 11'h400;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [1:0] FLAG_A_BIT = 2'h1;
  localparam logic [1:0] FLAG_P_BIT = 2'h2;

  typedef struct packed {
    logic pause;
    logic [2:0] clk_sel;
    logic on;
    logic [2:0] p_val;
  } stt_ctl0_s;

  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] out_func;
    logic out_ctl;
    logic out_pol;
    logic swap;
    logic clr_sel;
  } stt_ctl1_s;

  typedef struct packed {
    stt_ctl0_s ctl0;
    stt_ctl1_s ctl1;
    logic [9:0] cnt;
    logic [9:0] compare_a_value;
    logic on_prev;
    logic cap_prev;
    logic flag_a;
    logic flag_p;
    logic out_lvl;
    logic pin;
    logic pin_oe;
    logic ack;
    logic [7:0] rdata;
  } stt_state_s;

  typedef struct packed {
    logic [5:0] div;
    logic ext_prev;
  } stt_tick_s;

endpackage : stt_pkg

// ### stt_props.sv
`timescale 1ns/100ps
`default_nettype none
module stt_props (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  input wire logic EXT_CLOCK_PIN,
  input wire logic CAPTURE_INPUT_PIN,
  input wire logic TBC_TICK,
  input wire logic OUTPUT_PIN,
  input wire logic OUTPUT_PIN_OE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  stt_pkg::stt_ctl1_s c1_reg;
  logic on_reg;
  logic [2:0] age_reg;
  logic acc;
  logic rd_ok;
  assign acc = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0];
  assign rd_ok = AVS_READ && !AVS_WAITREQUEST;
  // shadows software writes only; a hardware clear of the on bit is missed
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      c1_reg <= '0;
      on_reg <= 1'b0;
      age_reg <= 3'h0;
    end else begin
      if (acc && AVS_ADDRESS == stt_pkg::OFS_CTL_ONE) c1_reg <= AVS_WRITEDATA[7:0];
      if (acc && AVS_ADDRESS == stt_pkg::OFS_CTL_ZERO) on_reg <= AVS_WRITEDATA[3];
      if (acc && AVS_ADDRESS == stt_pkg::OFS_CTL_ONE) age_reg <= 3'h0;
      else if (age_reg != 3'h7) age_reg <= age_reg + 3'h1;
    end
  end
  ////////////////////////////////////////
  AST_BUS_ANSWER: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
    |=> !AVS_WAITREQUEST) else $error("bus not answered after one wait");
  AST_BUS_IDLE: assert property (!AVS_READ && !AVS_WRITE |-> !AVS_WAITREQUEST)
    else $error("wait raised while idle");
  AST_CNT_HIGH: assert property (rd_ok && AVS_ADDRESS == stt_pkg::OFS_CNT_HIGH
    |-> AVS_READDATA[31:2] == 30'h0) else $error("counter high bits not zero");
  AST_CMPA_HIGH: assert property (rd_ok && AVS_ADDRESS == stt_pkg::OFS_CMPA_HIGH
    |-> AVS_READDATA[31:2] == 30'h0) else $error("compare high bits not zero");
  AST_NO_DRIVE: assert property (age_reg == 3'h7 && c1_reg.mode[0]
    |-> !OUTPUT_PIN_OE) else $error("pin driven in timer or capture mode");
  AST_DRIVE: assert property (age_reg == 3'h7 && !c1_reg.mode[0]
    |-> OUTPUT_PIN_OE) else $error("pin not driven in output mode");
  AST_PWM_FORCE: assert property (age_reg == 3'h7 && !c1_reg.out_func[1]
    && c1_reg.mode == stt_pkg::MODE_PWM_PULSE
    |-> OUTPUT_PIN == ((c1_reg.out_func[0] == c1_reg.out_ctl) ^ c1_reg.out_pol))
    else $error("forced pwm level wrong");
  AST_ON_INIT: assert property (acc && AVS_ADDRESS == stt_pkg::OFS_CTL_ZERO
    && AVS_WRITEDATA[3] && !on_reg && age_reg == 3'h7 && !c1_reg.out_pol
    && c1_reg.mode == stt_pkg::MODE_COMPARE |-> ##[1:3] OUTPUT_PIN == c1_reg.out_ctl)
    else $error("pin not set to initial level");
  cover property (acc && AVS_ADDRESS == stt_pkg::OFS_CTL_ONE);
  cover property (rd_ok && AVS_ADDRESS == stt_pkg::OFS_CMPA_LOW);
  cover property ($rose(OUTPUT_PIN));
endmodule : stt_props
bind stt_top stt_props u_props (.*);
`default_nettype wire

// ### stt_tick.sv
`timescale 1ns/100ps
`default_nettype none

module stt_tick (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] clk_sel,
  input wire logic ext_pin,
  input wire logic tbc_tick,
  output logic tick,
  output logic trig_edge
);

  stt_pkg::stt_tick_s s_reg;
  stt_pkg::stt_tick_s s_next;
  logic rise;
  logic fall;

  always_comb begin
    s_next = s_reg;
    s_next.div = s_reg.div + 6'h01;
    s_next.ext_prev = ext_pin;
    rise = ext_pin & ~s_reg.ext_prev;
    fall = ~ext_pin & s_reg.ext_prev;
    // fH is taken as the system clock; fTBC arrives as a one-cycle pulse
    unique case (clk_sel)
      stt_pkg::CLK_SYS_DIV4: tick = (s_reg.div[1:0] == 2'h3);
      stt_pkg::CLK_SYS: tick = 1'b1;
      stt_pkg::CLK_H_DIV16: tick = (s_reg.div[3:0] == 4'hf);
      stt_pkg::CLK_H_DIV64: tick = (s_reg.div == 6'h3f);
      stt_pkg::CLK_TBC: tick = tbc_tick;
      stt_pkg::CLK_H_DIV8: tick = (s_reg.div[2:0] == 3'h7);
      stt_pkg::CLK_EXT_RISE: tick = rise;
      stt_pkg::CLK_EXT_FALL: tick = fall;
    endcase
    // the trigger edge follows the selected pin edge, rising otherwise
    trig_edge = (clk_sel == stt_pkg::CLK_EXT_FALL) ? fall : rise;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

endmodule : stt_tick

`default_nettype wire

// ### stt_top.sv
// Our own choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

module stt_top (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic EXT_CLOCK_PIN,
  input wire logic CAPTURE_INPUT_PIN,
  input wire logic TBC_TICK,
  output logic OUTPUT_PIN,
  output logic OUTPUT_PIN_OE
);

  ////////////////////////////////////////////////////////////////////////
  // reset release

  logic [1:0] rst_sync;
  logic rst_n;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  assign rst_n = rst_sync[1];

  ////////////////////////////////////////////////////////////////////////
  // clock source

  stt_pkg::stt_state_s s_reg;
  stt_pkg::stt_state_s s_next;
  logic tick;
  logic trig_edge;

  stt_tick u_tick (
    .clk(CLK),
    .rst_n(rst_n),
    .clk_sel(s_reg.ctl0.clk_sel),
    .ext_pin(EXT_CLOCK_PIN),
    .tbc_tick(TBC_TICK),
    .tick(tick),
    .trig_edge(trig_edge)
  );

  ////////////////////////////////////////////////////////////////////////
  // register read decode

  function automatic logic [7:0] read_mux(
    input logic [4:0] addr,
    input stt_pkg::stt_state_s s
  );
    logic [7:0] v;
    v = 8'h00;
    unique case (addr)
      stt_pkg::OFS_CTL_ZERO: v = s.ctl0;
      stt_pkg::OFS_CTL_ONE: v = s.ctl1;
      stt_pkg::OFS_CNT_LOW: v = s.cnt[7:0];
      stt_pkg::OFS_CNT_HIGH: v = {6'h00, s.cnt[9:8]};
      stt_pkg::OFS_CMPA_LOW: v = s.compare_a_value[7:0];
      stt_pkg::OFS_CMPA_HIGH: v = {6'h00, s.compare_a_value[9:8]};
      stt_pkg::OFS_FLAGS: v = {6'h00, s.flag_p, s.flag_a};
      default: v = 8'h00;
    endcase
    return v;
  endfunction : read_mux

  ////////////////////////////////////////////////////////////////////////
  // timer core and bus slave

  logic [1:0] mode;
  logic [1:0] func;
  logic is_cmp_like;
  logic is_pwm;
  logic is_pulse;
  logic is_cap;
  logic on_rise;
  logic run;
  logic [9:0] cnt_inc;
  logic p_hit;
  logic a_hit;
  logic a_match;
  logic p_match;
  logic do_clear;
  logic [10:0] p_span;
  logic [10:0] a_span;
  logic [10:0] duty;
  logic pwm_act;
  logic act;
  logic cap_rise;
  logic cap_fall;
  logic cap_ev;
  logic bus_wr;
  logic [7:0] wd;
  logic clr_a;
  logic clr_p;

  always_comb begin
    s_next = s_reg;
    mode = s_reg.ctl1.mode;
    func = s_reg.ctl1.out_func;
    is_cmp_like = (mode == stt_pkg::MODE_COMPARE) || (mode == stt_pkg::MODE_TIMER);
    is_pwm = (mode == stt_pkg::MODE_PWM_PULSE) && (func != stt_pkg::IO_CODE_3);
    is_pulse = (mode == stt_pkg::MODE_PWM_PULSE) && (func == stt_pkg::IO_CODE_3);
    is_cap = (mode == stt_pkg::MODE_CAPTURE);

    // an on-bit rising edge restarts from zero and takes the place of a tick
    on_rise = s_reg.ctl0.on & ~s_reg.on_prev;
    s_next.on_prev = s_reg.ctl0.on;
    run = s_reg.ctl0.on & ~s_reg.ctl0.pause & tick & ~on_rise;
    cnt_inc = s_reg.cnt + 10'h001;

    // P compares only the top three bits, so a zero P means overflow
    if (s_reg.ctl0.p_val == 3'h0) begin
      p_hit = (s_reg.cnt == stt_pkg::CNT_MAX);
    end else begin
      p_hit = (cnt_inc == {s_reg.ctl0.p_val, 7'h00});
    end
    a_hit = (cnt_inc == s_reg.compare_a_value);
    a_match = run & a_hit;
    p_match = run & p_hit;

    p_span = (s_reg.ctl0.p_val == 3'h0) ? stt_pkg::SPAN_FULL : {1'b0, s_reg.ctl0.p_val, 7'h00};
    a_span = (s_reg.compare_a_value == 10'h000) ? stt_pkg::SPAN_FULL : {1'b0, s_reg.compare_a_value};
    duty = s_reg.ctl1.swap ? p_span : a_span;
    // the counter never reaches the period, so duty >= period stays active
    pwm_act = ({1'b0, s_reg.cnt} < duty);

    do_clear = 1'b0;
    if (is_cmp_like) begin
      do_clear = s_reg.ctl1.clr_sel ? a_match : p_match;
    end else if (is_pwm) begin
      do_clear = s_reg.ctl1.swap ? a_match : p_match;
    end else if (is_cap) begin
      do_clear = p_match;
    end

    if (on_rise) begin
      s_next.cnt = 10'h000;
    end else if (run) begin
      s_next.cnt = do_clear ? 10'h000 : cnt_inc;
    end

    // capture pin edges
    s_next.cap_prev = CAPTURE_INPUT_PIN;
    cap_rise = CAPTURE_INPUT_PIN & ~s_reg.cap_prev;
    cap_fall = ~CAPTURE_INPUT_PIN & s_reg.cap_prev;
    unique case (func)
      stt_pkg::IO_CODE_0: cap_ev = cap_rise;
      stt_pkg::IO_CODE_1: cap_ev = cap_fall;
      stt_pkg::IO_CODE_2: cap_ev = cap_rise | cap_fall;
      stt_pkg::IO_CODE_3: cap_ev = 1'b0;
    endcase
    cap_ev = cap_ev & is_cap & s_reg.ctl0.on;

    // bus: a write takes effect on the edge where waitrequest is low; a read samples the registers one edge earlier
    bus_wr = AVS_WRITE & s_reg.ack & AVS_BYTEENABLE[0];
    wd = AVS_WRITEDATA[7:0];
    s_next.ack = (AVS_READ | AVS_WRITE) & ~s_reg.ack;
    if (AVS_READ & ~s_reg.ack) begin
      s_next.rdata = read_mux(AVS_ADDRESS, s_reg);
    end
    clr_a = 1'b0;
    clr_p = 1'b0;
    if (bus_wr) begin
      unique case (AVS_ADDRESS)
        stt_pkg::OFS_CTL_ZERO: s_next.ctl0 = wd;
        stt_pkg::OFS_CTL_ONE: s_next.ctl1 = wd;
        stt_pkg::OFS_CMPA_LOW: s_next.compare_a_value[7:0] = wd;
        stt_pkg::OFS_CMPA_HIGH: s_next.compare_a_value[9:8] = wd[1:0];
        stt_pkg::OFS_FLAGS: begin
          clr_a = |(wd[1:0] & stt_pkg::FLAG_A_BIT);
          clr_p = |(wd[1:0] & stt_pkg::FLAG_P_BIT);
        end
        default: s_next.ctl0 = s_reg.ctl0;
      endcase
    end

    // a capture arriving with a software write to A wins
    if (cap_ev) begin
      s_next.compare_a_value = s_reg.cnt;
    end

    // hardware owns the on bit in pulse mode over a same-cycle write
    if (is_pulse && a_match) begin
      s_next.ctl0.on = 1'b0;
    end else if (is_pulse && trig_edge && !s_reg.ctl0.on) begin
      s_next.ctl0.on = 1'b1;
    end

    // flags: set wins over the software clear
    if (clr_a) begin
      s_next.flag_a = 1'b0;
    end
    if (clr_p) begin
      s_next.flag_p = 1'b0;
    end
    if ((a_match && !is_cap) || cap_ev) begin
      s_next.flag_a = 1'b1;
    end
    if (p_match && !is_pulse && !(is_cmp_like && s_reg.ctl1.clr_sel)) begin
      s_next.flag_p = 1'b1;
    end

    // compare-mode output level
    if (on_rise) begin
      s_next.out_lvl = s_reg.ctl1.out_ctl;
    end else if (a_match && mode == stt_pkg::MODE_COMPARE) begin
      unique case (func)
        stt_pkg::IO_CODE_0: s_next.out_lvl = s_reg.out_lvl;
        stt_pkg::IO_CODE_1: s_next.out_lvl = 1'b0;
        stt_pkg::IO_CODE_2: s_next.out_lvl = 1'b1;
        stt_pkg::IO_CODE_3: s_next.out_lvl = ~s_reg.out_lvl;
      endcase
    end

    // waveform modes: act is the logical active state before polarity
    unique case (func)
      stt_pkg::IO_CODE_0: act = 1'b0;
      stt_pkg::IO_CODE_1: act = 1'b1;
      stt_pkg::IO_CODE_2: act = pwm_act & s_reg.ctl0.on;
      stt_pkg::IO_CODE_3: act = s_reg.ctl0.on;
    endcase

    unique case (mode)
      stt_pkg::MODE_COMPARE: begin
        s_next.pin = s_next.out_lvl ^ s_reg.ctl1.out_pol;
        s_next.pin_oe = 1'b1;
      end
      stt_pkg::MODE_PWM_PULSE: begin
        s_next.pin = (act ? s_reg.ctl1.out_ctl : ~s_reg.ctl1.out_ctl) ^ s_reg.ctl1.out_pol;
        s_next.pin_oe = 1'b1;
      end
      stt_pkg::MODE_CAPTURE: begin
        s_next.pin = 1'b0;
        s_next.pin_oe = 1'b0;
      end
      stt_pkg::MODE_TIMER: begin
        s_next.pin = 1'b0;
        s_next.pin_oe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  // waitrequest holds one cycle, so every access takes two edges
  assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~s_reg.ack;
  assign AVS_READDATA = {24'h00_0000, s_reg.rdata};
  assign OUTPUT_PIN = s_reg.pin;
  assign OUTPUT_PIN_OE = s_reg.pin_oe;

endmodule : stt_top

`default_nettype wire

// ### stt_top_test.sv
`timescale 1ns/100ps
`default_nettype none
module stt_top_test;
  localparam logic [4:0] C0 = stt_pkg::OFS_CTL_ZERO, C1 = stt_pkg::OFS_CTL_ONE,
    CH = stt_pkg::OFS_CNT_HIGH, CL = stt_pkg::OFS_CNT_LOW, AL = stt_pkg::OFS_CMPA_LOW,
    AH = stt_pkg::OFS_CMPA_HIGH, FL = stt_pkg::OFS_FLAGS;
  logic CLK = 1'b0;
  logic RST_N, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, OUTPUT_PIN, OUTPUT_PIN_OE;
  logic EXT_CLOCK_PIN, CAPTURE_INPUT_PIN, TBC_TICK;
  logic [4:0] AVS_ADDRESS;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA, q;
  logic [3:0] AVS_BYTEENABLE;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  int c;
  always #12.5 CLK = ~CLK;
  stt_top dut (.*);
  stt_pins pins (.clk(CLK), .ext_pin(EXT_CLOCK_PIN), .cap_pin(CAPTURE_INPUT_PIN),
    .tbc(TBC_TICK));
  ////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude
  // the whole run needs under 10000 cycles
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      conclude();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: got %h, want %h", $time, g, e);
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n) @(posedge CLK);
  endtask : idle
  // request held until a rising edge sees waitrequest low; data taken at that edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge CLK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= {24'h00_0000, d};
    AVS_WRITE <= w;
    AVS_READ <= !w;
    do begin
      @(posedge CLK);
    end while (AVS_WAITREQUEST !== 1'b0);
    q = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
  endtask : bus
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 8'h00);
    chk(q, e);
  endtask : rd
  task automatic hi(input int n);
    c = 0;
    repeat (n) begin
      @(negedge CLK);
      if (OUTPUT_PIN === 1'b1) c++;
    end
  endtask : hi
  task automatic meas(input int n, input logic [31:0] e);
    idle(300);
    hi(n);
    chk(c, e);
  endtask : meas
  // modes are only changed with the counter off
  task automatic start(input logic [7:0] c1v, input logic [7:0] c0v);
    wr(C0, 8'h10);
    wr(C1, c1v);
    idle(8);
    wr(C0, c0v);
    wr(FL, 8'h03);
  endtask : start
  ////////////////////////////////////////
  task automatic t_regs();
    rd(CH, 32'h0000_0000);
    rd(AL, 32'h0000_0000);
    wr(AL, 8'ha5);
    wr(AH, 8'hff);
    wr(CH, 8'hff);
    AVS_BYTEENABLE <= 4'h0;
    wr(AL, 8'h5a);
    AVS_BYTEENABLE <= 4'h1;
    rd(AL, 32'h0000_00a5);
    rd(AH, 32'h0000_0003);
    rd(CH, 32'h0000_0000);
    rd(5'h1c, 32'h0000_0000);
    $display("register test done");
  endtask : t_regs
  task automatic t_cmp();
    logic [7:0] cfg [3] = '{8'h09, 8'h19, 8'h21};
    logic lvl [3] = '{1'b1, 1'b0, 1'b1};
    wr(AL, 8'h64);
    wr(AH, 8'h00);
    start(8'h39, 8'h18);
    meas(400, 200);
    rd(FL, 32'h0000_0001);
    rd(CH, 32'h0000_0000);
    for (int k = 0; k < 3; k++) begin
      start(cfg[k], 8'h18);
      idle(250);
      chk(OUTPUT_PIN, lvl[k]);
    end
    start(8'h08, 8'h19);
    idle(300);
    rd(FL, 32'h0000_0003);
    rd(CH, 32'h0000_0000);
    start(8'hc0, 8'h19);
    idle(300);
    rd(FL, 32'h0000_0003);
    $display("compare test done");
  endtask : t_cmp
  task automatic t_pwm();
    wr(AL, 8'h20);
    start(8'ha9, 8'h19);
    meas(256, 64);
    rd(FL, 32'h0000_0003);
    wr(AL, 8'hc8);
    meas(256, 256);
    wr(AL, 8'h20);
    start(8'had, 8'h19);
    meas(256, 192);
    wr(AL, 8'h00);
    wr(AH, 8'h01);
    start(8'hab, 8'h19);
    meas(512, 256);
    start(8'h89, 8'h19);
    idle(12);
    chk(OUTPUT_PIN, 32'h0);
    start(8'h99, 8'h19);
    idle(12);
    chk(OUTPUT_PIN, 32'h1);
    $display("pwm test done");
  endtask : t_pwm
  task automatic t_pulse();
    wr(AH, 8'h00);
    wr(AL, 8'h32);
    start(8'hb8, 8'h10);
    fork
      pins.hit(1'b0);
      hi(200);
    join
    chk({31'h0, c == 50 || c == 51}, 32'h1);
    rd(C0, 32'h0000_0010);
    rd(FL, 32'h0000_0001);
    fork
      wr(C0, 8'h18);
      hi(200);
    join
    chk({31'h0, c == 50 || c == 51}, 32'h1);
    $display("pulse test done");
  endtask : t_pulse
  task automatic t_cap();
    logic [31:0] c1;
    start(8'h40, 8'h18);
    idle(20);
    bus(1'b0, CL, 8'h00);
    c1 = q;
    pins.hit(1'b1);
    bus(1'b0, AL, 8'h00);
    chk({31'h0, q > c1 && q < c1 + 32'd20}, 32'h1);
    rd(AH, 32'h0000_0000);
    rd(FL, 32'h0000_0001);
    wr(C1, 8'h70);
    wr(FL, 8'h03);
    pins.hit(1'b1);
    rd(FL, 32'h0000_0000);
    wr(C0, 8'h19);
    idle(300);
    rd(FL, 32'h0000_0002);
    rd(CH, 32'h0000_0000);
    $display("capture test done");
  endtask : t_cap
  initial begin
    RST_N = 1'b0;
    AVS_ADDRESS = 5'h00;
    AVS_READ = 1'b0;
    AVS_WRITE = 1'b0;
    AVS_WRITEDATA = 32'h0000_0000;
    AVS_BYTEENABLE = 4'h1;
    idle(16);
    RST_N <= 1'b1;
    idle(4);
    t_regs();
    t_cmp();
    t_pwm();
    t_pulse();
    t_cap();
    conclude();
  end
endmodule : stt_top_test
`default_nettype wire
